// File: include/acsp_pkg.sv
// Notes on behaviour
// - busy_n stays low throughout a conversion and goes high when it ends.
// - with rd_n low, first result bit is on sdo before busy_n rises.
// - sdo moves to the next bit only after a falling sck edge.
// - sdi is sampled on each of the first 8 rising sck edges while rd_n is low.
// - 8-bit control word (channel, range, power-down) enters on first 8 rising edges.
// - acquisition starts at the sixth falling edge, lasts until convert_start rises.
// - convert_start rising starts a conversion; further starts ignored until it ends.
// - sdo driven only while rd_n low; sdi ignored while rd_n high.
package acsp_pkg;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int CLK_MHZ = 100;
  localparam int TCONV_TYP_NS = 4000;
  localparam int TCONV_MAX_NS = 5000;
  // typical time sets the count, rounded down so the maximum is never passed
  localparam int CONV_CYC = TCONV_TYP_NS * CLK_MHZ / 1000;
  localparam int CONV_MAX_CYC = TCONV_MAX_NS * CLK_MHZ / 1000;
  localparam int CONV_CNT_W = 10;

  // ********************************************************
  // serial word layout
  // ********************************************************
  localparam int CTRL_W = 8;
  localparam int EDGE_CNT_W = 4;
  localparam int ACQ_EDGE = 6;
  localparam int RES_W_DEF = 16;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // ********************************************************
  // converter sequence, gray along idle-acq-conv-load
  // ********************************************************
  typedef enum logic [1:0] {
    ACSP_IDLE = 2'h0,
    ACSP_ACQ = 2'h1,
    ACSP_CONV = 2'h3,
    ACSP_LOAD = 2'h2
  } acsp_state_t;
endpackage

// File: src/acsp_fifo.sv
`timescale 1ns/1ps
module acsp_fifo
  import acsp_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } acsp_fifo_st_t;

  acsp_fifo_st_t r_reg, r_next;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty when the indices meet
  assign empty = (r_reg.wptr == r_reg.rptr);
  assign full = (r_reg.wptr[AW] != r_reg.rptr[AW]) &&
                (r_reg.wptr[AW-1:0] == r_reg.rptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = r_reg.mem[r_reg.rptr[AW-1:0]];

  // push and pop may happen in the same cycle
  always_comb begin
    r_next = r_reg;
    if (in_valid && !full) begin
      r_next.mem[r_reg.wptr[AW-1:0]] = in_data;
      r_next.wptr = r_reg.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      r_next.rptr = r_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  fifo_push_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((in_valid && in_ready) |=> out_valid))
    else $error("accepted word missing from fifo");
endmodule

// File: src/acsp_top.sv
`timescale 1ns/1ps
module acsp_top
  import acsp_pkg::*;
#(
  parameter int RES_W = RES_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic convert_start,
  input wire logic sck,
  input wire logic sdi,
  input wire logic rd_n,
  input wire logic [RES_W-1:0] sar_result,
  output logic busy_n,
  output logic sdo_out,
  output logic sdo_oe,
  output logic [CTRL_W-1:0] ctrl_word,
  output logic acquire
);
  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic sck_s1, sck_s2, sck_s3;
    logic sdi_s1, sdi_s2;
    logic rd_s1, rd_s2;
    logic cs_s1, cs_s2, cs_s3;
    acsp_state_t state;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic busy_n;
    logic sdo_oe;
    logic [EDGE_CNT_W-1:0] rise_cnt;
    logic [EDGE_CNT_W-1:0] fall_cnt;
    logic [CTRL_W-1:0] ctrl_shift;
    logic [CTRL_W-1:0] ctrl_word;
    logic [RES_W-1:0] shift_reg;
    logic [EDGE_CNT_W:0] bits_left;
    logic acquire;
  } acsp_top_st_t;

  acsp_top_st_t r_reg, r_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic sck_rise, sck_fall, cs_rise, rd_low;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [RES_W-1:0] fifo_out_data;
  logic load_word;

  // ********************************************************
  // reset release
  // ********************************************************
  // two stages so that release never lands near a clock edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ********************************************************
  // edge detection on synchronised pins
  // ********************************************************
  // only second and third stages are compared; the first stays private
  assign sck_rise = r_reg.sck_s2 && !r_reg.sck_s3;
  assign sck_fall = !r_reg.sck_s2 && r_reg.sck_s3;
  assign cs_rise = r_reg.cs_s2 && !r_reg.cs_s3;
  assign rd_low = !r_reg.rd_s2;

  // results queue here; a full queue holds the converter in its last step
  assign fifo_in_valid = (r_reg.state == ACSP_CONV) &&
                         (r_reg.conv_cnt == CONV_CNT_W'(CONV_CYC - 1));
  // the shifter always takes a finished word, so busy_n never waits on the host;
  // a word not yet clocked out is overwritten, as the conversion has ended
  assign fifo_out_ready = (r_reg.state == ACSP_LOAD);
  assign load_word = fifo_out_ready && fifo_out_valid;

  acsp_fifo #(
    .W(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) i_acsp_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(sar_result),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    r_next = r_reg;
    r_next.sck_s1 = sck;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_s3 = r_reg.sck_s2;
    r_next.sdi_s1 = sdi;
    r_next.sdi_s2 = r_reg.sdi_s1;
    r_next.rd_s1 = rd_n;
    r_next.rd_s2 = r_reg.rd_s1;
    r_next.cs_s1 = convert_start;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.cs_s3 = r_reg.cs_s2;
    r_next.sdo_oe = rd_low;

    // control word frame; counters clear whenever rd_n is high
    if (!rd_low) begin
      r_next.rise_cnt = '0;
      r_next.fall_cnt = '0;
    end else begin
      if (sck_rise && (r_reg.rise_cnt < EDGE_CNT_W'(CTRL_W))) begin
        r_next.ctrl_shift = {r_reg.ctrl_shift[CTRL_W-2:0], r_reg.sdi_s2};
        r_next.rise_cnt = r_reg.rise_cnt + 1'b1;
        if (r_reg.rise_cnt == EDGE_CNT_W'(CTRL_W - 1)) begin
          r_next.ctrl_word = {r_reg.ctrl_shift[CTRL_W-2:0], r_reg.sdi_s2};
        end
      end
      if (sck_fall && (r_reg.fall_cnt < EDGE_CNT_W'(CTRL_W))) begin
        r_next.fall_cnt = r_reg.fall_cnt + 1'b1;
        if ((r_reg.fall_cnt == EDGE_CNT_W'(ACQ_EDGE - 1)) && (r_reg.state == ACSP_IDLE)) begin
          r_next.state = ACSP_ACQ;
        end
      end
    end

    // result shifter: next bit only after a falling sck edge
    if (sck_fall && (r_reg.bits_left != '0)) begin
      r_next.shift_reg = {r_reg.shift_reg[RES_W-2:0], 1'b0};
      r_next.bits_left = r_reg.bits_left - 1'b1;
    end

    case (r_reg.state)
      ACSP_IDLE, ACSP_ACQ: begin
        // busy rises one cycle after the word reached sdo
        r_next.busy_n = 1'b1;
        if (cs_rise) begin
          r_next.state = ACSP_CONV;
          r_next.conv_cnt = '0;
          r_next.busy_n = 1'b0;
          r_next.rise_cnt = '0;
          r_next.fall_cnt = '0;
        end
      end
      ACSP_CONV: begin
        // start edges are not looked at here
        if (fifo_in_valid) begin
          if (fifo_in_ready) begin
            r_next.state = ACSP_LOAD;
          end
        end else begin
          r_next.conv_cnt = r_reg.conv_cnt + 1'b1;
        end
      end
      ACSP_LOAD: begin
        if (load_word) begin
          r_next.shift_reg = fifo_out_data;
          r_next.bits_left = (EDGE_CNT_W+1)'(RES_W);
          r_next.state = ACSP_IDLE;
        end
      end
      default: begin
        r_next.state = ACSP_IDLE;
      end
    endcase
    // acquire is kept as a flop of its own so the pin is glitch free
    r_next.acquire = (r_next.state == ACSP_ACQ);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.rd_s1 <= 1'b1;
      r_reg.rd_s2 <= 1'b1;
      r_reg.busy_n <= 1'b1;
      r_reg.state <= ACSP_IDLE;
      r_reg.ctrl_word <= CTRL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign busy_n = r_reg.busy_n;
  assign sdo_out = r_reg.shift_reg[RES_W-1];
  assign sdo_oe = r_reg.sdo_oe;
  assign ctrl_word = r_reg.ctrl_word;
  assign acquire = r_reg.acquire;

  // ********************************************************
  // checks
  // ********************************************************
  localparam int conv_lim = CONV_MAX_CYC;

  busy_low_conv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r_reg.state inside {ACSP_CONV, ACSP_LOAD}) |-> !busy_n)
    else $error("busy_n high during conversion");
  first_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busy_n) |-> ($past(r_reg.bits_left) == (EDGE_CNT_W+1)'(RES_W)))
    else $error("busy_n rose before result was on sdo");
  sdo_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(r_reg.shift_reg) |-> ($past(sck_fall) || $past(load_word)))
    else $error("sdo changed without falling sck");
  sdi_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(r_reg.ctrl_shift) |-> $past(sck_rise && rd_low))
    else $error("sdi taken without rising sck");
  conv_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(busy_n) |-> ##[1:conv_lim] busy_n)
    else $error("conversion exceeded its maximum time");
  ctrl_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(ctrl_word) |-> ($past(r_reg.rise_cnt) == EDGE_CNT_W'(CTRL_W - 1)))
    else $error("control word latched at wrong edge");
  acq_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(acquire) |->
      ($past(sck_fall) && ($past(r_reg.fall_cnt) == EDGE_CNT_W'(ACQ_EDGE - 1))))
    else $error("acquisition entered at wrong edge");
  conv_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && (r_reg.state inside {ACSP_IDLE, ACSP_ACQ})) |=>
      ((r_reg.state == ACSP_CONV) && !busy_n))
    else $error("convert start not taken");
  start_ignored_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && (r_reg.state == ACSP_CONV) && !fifo_in_valid) |=>
      (($past(r_reg.conv_cnt) + 1'b1) == r_reg.conv_cnt))
    else $error("convert start restarted a conversion");
  read_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_low |=> (!sdo_oe && (r_reg.rise_cnt == '0)))
    else $error("sdo driven or sdi taken with rd_n high");

  conv_done_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(busy_n));
  ctrl_load_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $changed(ctrl_word));
  word_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(r_reg.bits_left == '0) ##0 rd_low);
  fifo_stall_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    fifo_in_valid && !fifo_in_ready);
endmodule

// File: verif/acsp_host_model.sv
`timescale 1ns/1ps
module acsp_host_model
  import acsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic sck,
  output logic sdi,
  output logic rd_n
);
  // ****************************************
  // host side of the serial link
  // ****************************************
  // serial clock stands low between frames
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    rd_n = 1'b1;
  end

  // a released line shows the opposite of the held bit, so a read outside
  // the enable window cannot pass by accident
  logic sdo_line;
  assign sdo_line = sdo_oe ? sdo_out : ~sdo_out;

  // one frame at 80 ns, 50% duty; control bits lead, result bits are taken
  // just before each falling sck, since 12.5 MHz is too fast for rising capture
  task automatic frame(input logic [CTRL_W-1:0] ctrl, input int nbits, input logic rd_lvl,
                       input bit keep_low, output logic [RES_W_DEF-1:0] rx);
    int i;
    rx = '0;
    @(posedge clk_sys);
    rd_n <= rd_lvl;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < nbits; i++) begin
      sdi <= (i < CTRL_W) ? ctrl[CTRL_W-1-i] : ~sdi;
      @(posedge clk_sys);
      sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rx = {rx[RES_W_DEF-2:0], sdo_line};
      sck <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    // released data line flips so a stale value is never mistaken for data
    sdi <= ~sdi;
    if (!keep_low) rd_n <= 1'b1;
    @(posedge clk_sys);
  endtask
endmodule

// File: verif/adc_serial_conversion_port_test.sv
`timescale 1ns/1ps
module adc_serial_conversion_port_test;
  import acsp_pkg::*;
  logic clk_sys;
  logic resetn;
  logic convert_start;
  logic [RES_W_DEF-1:0] sar_result;
  logic sck, sdi, rd_n, busy_n, sdo_out, sdo_oe, acquire;
  logic [CTRL_W-1:0] ctrl_word;
  logic [RES_W_DEF-1:0] rx;
  int n_fail = 0;
  int compares = 0;

  acsp_top i_acsp_top (.clk_sys(clk_sys), .resetn(resetn), .convert_start(convert_start),
    .sck(sck), .sdi(sdi), .rd_n(rd_n), .sar_result(sar_result), .busy_n(busy_n),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ctrl_word(ctrl_word), .acquire(acquire));
  acsp_host_model i_acsp_host_model (.clk_sys(clk_sys), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sck(sck), .sdi(sdi), .rd_n(rd_n));

  // ****************************************
  // clock, compares and closing
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // start pulse of 40 ns, optional second start mid conversion; returns the
  // busy low time and the sdo bit of the last busy low cycle
  task automatic conv(input logic [15:0] v, input bit again, output int n, output logic msb);
    int k;
    n = 0;
    msb = 1'b0;
    @(posedge clk_sys);
    sar_result <= v;
    convert_start <= 1'b1;
    repeat (4) @(posedge clk_sys);
    convert_start <= 1'b0;
    for (k = 0; k < 20 && busy_n !== 1'b0; k++) @(posedge clk_sys);
    for (k = 0; k < 700 && busy_n === 1'b0; k++) begin
      msb = sdo_out;
      @(posedge clk_sys);
      n++;
      if (again && k == 200) convert_start <= 1'b1;
      if (again && k == 205) convert_start <= 1'b0;
    end
    if (busy_n !== 1'b1 || n == 0) begin
      n_fail++;
      end_of_test();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk_bit("busy_n", 1'b1, busy_n);
    chk_bit("sdo_oe", 1'b0, sdo_oe);
    chk_bit("acquire", 1'b0, acquire);
    chk_word("ctrl_word", 16'h0000, {8'h00, ctrl_word});
  endtask

  // clocking with read enable high must leave the device untouched
  task automatic t_unselected();
    i_acsp_host_model.frame(8'h3c, 8, 1'b1, 1'b0, rx);
    chk_word("ctrl_word", 16'h0000, {8'h00, ctrl_word});
    chk_bit("acquire", 1'b0, acquire);
  endtask

  // five edges are short of acquisition, six reach it; neither is a full word
  task automatic t_partial();
    i_acsp_host_model.frame(8'hff, 5, 1'b0, 1'b0, rx);
    chk_bit("acquire", 1'b0, acquire);
    i_acsp_host_model.frame(8'hff, 6, 1'b0, 1'b0, rx);
    chk_bit("acquire", 1'b1, acquire);
    chk_word("ctrl_word", 16'h0000, {8'h00, ctrl_word});
  endtask

  task automatic t_convert();
    int n;
    logic b;
    i_acsp_host_model.frame(8'ha5, 16, 1'b0, 1'b0, rx);
    chk_word("ctrl_word", 16'h00a5, {8'h00, ctrl_word});
    // the enable follows rd_n through its synchroniser, a few cycles late
    repeat (4) @(posedge clk_sys);
    chk_bit("sdo_oe", 1'b0, sdo_oe);
    conv(16'hc3a6, 1'b1, n, b);
    chk_bit("acquire", 1'b0, acquire);
    chk_bit("busy_len", 1'b1, n >= CONV_CYC && n <= CONV_MAX_CYC);
    repeat (20) @(posedge clk_sys);
    chk_bit("busy_n", 1'b1, busy_n);
    i_acsp_host_model.frame(8'h5a, 16, 1'b0, 1'b0, rx);
    chk_word("result", 16'hc3a6, rx);
  endtask

  // read enable held low across the conversion end
  task automatic t_read_during_conv();
    int n;
    logic b;
    i_acsp_host_model.frame(8'h81, 16, 1'b0, 1'b1, rx);
    chk_bit("acquire", 1'b1, acquire);
    conv(16'h9f01, 1'b0, n, b);
    chk_bit("sdo_first", 1'b1, b);
    chk_bit("sdo_oe", 1'b1, sdo_oe);
    i_acsp_host_model.frame(8'h00, 16, 1'b0, 1'b0, rx);
    chk_word("result", 16'h9f01, rx);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    convert_start = 1'b0;
    sar_result = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_unselected();
    t_partial();
    t_convert();
    t_read_during_conv();
    end_of_test();
  end
endmodule
